// ---- dv/vrc_controller_tb_top.sv ----
module vrc_controller_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int CH = vrc_pkg::NUM_CHANNELS;
	localparam int PW = vrc_pkg::PRIO_WIDTH;
	localparam int PN = vrc_pkg::NUM_PORT_PINS;
	localparam int X3 = vrc_pkg::EXT_LINE_THREE_CHANNEL;
	// ----------------------------------------
	// stimulus and observation
	// ----------------------------------------
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic [CH-1:0] requestIn = '0, fastSelect = '0, enable = '0;
	logic [PN-1:0] pinIn = '0, riseEnable = '0, fallEnable = '0, pinClear = '0;
	logic [CH*PW-1:0] prioFlat = '1;
	logic [CH*32-1:0] vectorFlat = '0;
	logic fastRequest, normalRequest, servingFast, servingNormal;
	logic [CH-1:0] fastStatus;
	logic [31:0] vectorAddr;
	logic [$clog2(CH)-1:0] activeChannel;
	logic [PN-1:0] pinStatus;
	int fails = 0;
	int totalChecks = 0;
	always #25 clk = ~clk;
	vrc_controller u_dut (.clk(clk), .reset(reset), .requestIn(requestIn), .pinIn(pinIn),
		.riseEnable(riseEnable), .fallEnable(fallEnable), .pinClear(pinClear),
		.fastSelect(fastSelect), .enable(enable), .prioFlat(prioFlat), .vectorFlat(vectorFlat),
		.fastRequest(fastRequest), .normalRequest(normalRequest), .fastStatus(fastStatus),
		.vectorAddr(vectorAddr), .activeChannel(activeChannel), .pinStatus(pinStatus));
	vrc_core_model u_core (.clk(clk), .reset(reset), .fastRequest(fastRequest),
		.normalRequest(normalRequest), .servingFast(servingFast), .servingNormal(servingNormal));
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [31:0] vecAddr(int i);
		return 32'h0000_1000 + 32'h10 * i;
	endfunction
	task automatic step(int n);
		repeat (n) @(posedge clk);
		#5;
	endtask
	task automatic chk(logic [31:0] seen, logic [31:0] exp, string what);
		totalChecks++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] %0t %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask
	task automatic finalReport();
		$display("checks %0d mismatches %0d", totalChecks, fails);
		if (fails == 0 && totalChecks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic testNormal();
		enable = '1;
		prioFlat[2*PW+:PW] = 4'h7;
		prioFlat[5*PW+:PW] = 4'h3;
		prioFlat[9*PW+:PW] = 4'h3;
		requestIn = 32'h0000_0224; // one level per peripheral
		step(1);
		chk(32'(normalRequest), 32'h1, "normal level");
		chk(32'(fastRequest), 32'h0, "no fast");
		chk(32'(activeChannel), 32'h5, "tie winner");
		chk(vectorAddr, vecAddr(5), "vector");
		prioFlat[9*PW+:PW] = 4'h1;
		step(1);
		chk(32'(activeChannel), 32'h9, "priority winner");
		enable[9] = 1'b0;
		step(1);
		chk(32'(activeChannel), 32'h5, "disabled ignored");
		requestIn = '0;
		step(1);
		chk(32'(normalRequest), 32'h0, "normal drop");
		chk(vectorAddr, 32'h0, "vector idle");
		$display("test normal done");
	endtask
	task automatic testFast();
		enable = '1;
		requestIn = 32'h8000_0011;
		fastSelect = 32'h8000_0001;
		step(1);
		chk(32'(fastRequest), 32'h1, "fast or");
		chk(fastStatus, 32'h8000_0001, "fast word");
		chk(32'(activeChannel), 32'h4, "vectored rest");
		step(1);
		chk(32'({servingFast, servingNormal}), 32'h2, "fast first");
		fastSelect = 32'h0000_0001;
		step(1);
		chk(fastStatus, 32'h1, "reassigned");
		requestIn[0] = 1'b0;
		step(1);
		chk(32'(fastRequest), 32'h0, "fast drop");
		requestIn = '0;
		fastSelect = '0;
		step(1);
		$display("test fast done");
	endtask
	task automatic testPins();
		logic exp;
		for (int m = 1; m < 4; m++) begin
			riseEnable[40] = m[0];
			fallEnable[40] = m[1];
			for (int e = 0; e < 2; e++) begin
				pinIn[40] = ~pinIn[40];
				step(5);
				exp = pinIn[40] ? m[0] : m[1];
				chk(32'(pinStatus[40]), 32'(exp), "pin edge");
				chk(32'(activeChannel), exp ? 32'(X3) : 32'h0, "pin channel");
				pinClear[40] = 1'b1;
				step(1);
				pinClear[40] = 1'b0;
				step(1);
				chk(32'(normalRequest), 32'h0, "pin cleared");
			end
		end
		$display("test pins done");
	endtask
	// ----------------------------------------
	// main sequence and watchdog
	// ----------------------------------------
	initial begin
		for (int i = 0; i < CH; i++) vectorFlat[32*i+:32] = vecAddr(i);
		repeat (6) @(posedge clk);
		#5 reset = 1'b0;
		step(1);
		testNormal();
		testFast();
		testPins();
		finalReport();
	end
	initial begin
		#100000;
		fails++;
		finalReport();
	end
endmodule

// ---- dv/vrc_core_model.sv ----
module vrc_core_model (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// request levels from the controller
	input wire logic fastRequest,
	input wire logic normalRequest,
	// what the core would service next
	output logic servingFast,
	output logic servingNormal
);
	timeunit 1ns;
	timeprecision 1ns;
	// ----------------------------------------
	// service choice
	// ----------------------------------------
	// fast wins so a fast source never waits behind a normal handler
	always_ff @(posedge clk) begin
		servingFast <= !reset && fastRequest;
		servingNormal <= !reset && normalRequest && !fastRequest;
	end
endmodule

// ---- hw/vrc_controller.sv ----
module vrc_controller #(
	parameter int CHANNELS = vrc_pkg::NUM_CHANNELS,
	parameter int PW = vrc_pkg::PRIO_WIDTH,
	parameter int PINS = vrc_pkg::NUM_PORT_PINS,
	parameter int EXT3 = vrc_pkg::EXT_LINE_THREE_CHANNEL
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// peripheral request lines, one per peripheral, same clock
	input wire logic [CHANNELS-1:0] requestIn,
	// port pins and their edge configuration
	input wire logic [PINS-1:0] pinIn,
	input wire logic [PINS-1:0] riseEnable,
	input wire logic [PINS-1:0] fallEnable,
	input wire logic [PINS-1:0] pinClear,
	// configuration
	input wire logic [CHANNELS-1:0] fastSelect,
	input wire logic [CHANNELS-1:0] enable,
	input wire logic [CHANNELS*PW-1:0] prioFlat,
	input wire logic [CHANNELS*32-1:0] vectorFlat,
	// outputs to the core
	output logic fastRequest,
	output logic normalRequest,
	output logic [CHANNELS-1:0] fastStatus,
	output logic [31:0] vectorAddr,
	output logic [$clog2(CHANNELS)-1:0] activeChannel,
	output logic [PINS-1:0] pinStatus
);
	// ----------------------------------------
	// elaboration checks
	// ----------------------------------------
	initial begin
		if (CHANNELS < 2) $error("vrc_controller: at least 2 channels");
		if (CHANNELS > 32) $error("vrc_controller: at most 32 channels");
		if (PW < 1) $error("vrc_controller: priority width must be positive");
		if (PINS < 1) $error("vrc_controller: PINS must be positive");
		if (EXT3 < 0 || EXT3 >= CHANNELS) $error("vrc_controller: EXT3 out of range");
	end

	logic portRequest;
	logic [CHANNELS-1:0] merged;
	logic [CHANNELS-1:0] active;
	logic [CHANNELS-1:0] fastAct;
	logic [CHANNELS-1:0] normAct;
	logic found;
	logic [$clog2(CHANNELS)-1:0] winner;
	logic fastRequest_q;
	logic normalRequest_q;
	logic [CHANNELS-1:0] fastStatus_q;
	logic [31:0] vectorAddr_q;
	logic [$clog2(CHANNELS)-1:0] activeChannel_q;
	logic betterExists;
	logic lowerTie;
	logic [PW-1:0] winPrio;

	// ----------------------------------------
	// field slicing; priority for the check reference, vector for the outputs
	// ----------------------------------------
	function automatic logic [PW-1:0] prioOf(
		input logic [CHANNELS*PW-1:0] flat,
		input int ch
	);
		return flat[ch*PW +: PW];
	endfunction

	function automatic logic [31:0] vectorOf(
		input logic [CHANNELS*32-1:0] flat,
		input int ch
	);
		return flat[ch*32 +: 32];
	endfunction

	// ----------------------------------------
	// port edge detection
	// ----------------------------------------
	vrc_port_edge #(.PINS(PINS)) u_edge (
		.clk(clk),
		.reset(reset),
		.pinIn(pinIn),
		.riseEnable(riseEnable),
		.fallEnable(fallEnable),
		.pinClear(pinClear),
		.pinStatus(pinStatus),
		.portRequest(portRequest)
	);

	// ----------------------------------------
	// classification
	// ----------------------------------------
	always_comb begin
		merged = requestIn;
		merged[EXT3] = requestIn[EXT3] | portRequest;
	end
	assign active = merged & enable;
	assign fastAct = active & fastSelect;
	assign normAct = active & ~fastSelect;

	vrc_prio_pick #(.CHANNELS(CHANNELS), .PW(PW)) u_pick (
		.pending(normAct),
		.prioFlat(prioFlat),
		.found(found),
		.winner(winner)
	);

	// ----------------------------------------
	// check reference; each pending channel compared with the winner, kept apart from the picker's scan
	// ----------------------------------------
	always_comb begin
		betterExists = 1'b0;
		lowerTie = 1'b0;
		winPrio = prioOf(prioFlat, int'(winner));
		for (int i = 0; i < CHANNELS; i++) begin
			if (normAct[i] && prioOf(prioFlat, i) < winPrio) begin
				betterExists = 1'b1;
			end
			if (normAct[i] && i < int'(winner) && prioOf(prioFlat, i) == winPrio) begin
				lowerTie = 1'b1;
			end
		end
	end

	// ----------------------------------------
	// fast class outputs
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (reset) begin
			fastRequest_q <= 1'b0;
		end else begin
			fastRequest_q <= |fastAct;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			fastStatus_q <= '0;
		end else begin
			fastStatus_q <= fastAct;
		end
	end

	// ----------------------------------------
	// vectored class outputs
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (reset) begin
			normalRequest_q <= 1'b0;
		end else begin
			normalRequest_q <= |normAct;
		end
	end

	// no winner shows the reset address, so a stale handler is never offered
	always_ff @(posedge clk) begin
		if (reset) begin
			vectorAddr_q <= vrc_pkg::ADDR_RESET;
		end else if (found) begin
			vectorAddr_q <= vectorOf(vectorFlat, int'(winner));
		end else begin
			vectorAddr_q <= vrc_pkg::ADDR_RESET;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			activeChannel_q <= '0;
		end else if (found) begin
			activeChannel_q <= winner;
		end else begin
			activeChannel_q <= '0;
		end
	end

	assign fastRequest = fastRequest_q;
	assign normalRequest = normalRequest_q;
	assign fastStatus = fastStatus_q;
	assign vectorAddr = vectorAddr_q;
	assign activeChannel = activeChannel_q;

	// ----------------------------------------
	// checks: output levels
	// ----------------------------------------
	chk_fast_or: assert property (
		@(posedge clk) disable iff (reset)
		(|fastAct) |=> fastRequest
	) else $error("fast output missed");

	chk_fast_drop: assert property (
		@(posedge clk) disable iff (reset)
		!(|fastAct) |=> !fastRequest
	) else $error("fast output stuck");

	chk_norm_or: assert property (
		@(posedge clk) disable iff (reset)
		(|normAct) |=> normalRequest
	) else $error("normal output missed");

	chk_norm_drop: assert property (
		@(posedge clk) disable iff (reset)
		!(|normAct) |=> !normalRequest
	) else $error("normal output stuck");

	chk_status_word: assert property (
		@(posedge clk) disable iff (reset)
		1'b1 |=> (fastStatus == $past(fastAct))
	) else $error("status word wrong");

	chk_status_or: assert property (
		@(posedge clk) disable iff (reset)
		1'b1 |-> (fastRequest == (|fastStatus))
	) else $error("status word and fast output disagree");

	chk_both_raise: assert property (
		@(posedge clk) disable iff (reset)
		((|fastAct) && (|normAct)) |=> (fastRequest && normalRequest)
	) else $error("fast output held back");

	chk_disabled_quiet: assert property (
		@(posedge clk) disable iff (reset)
		(enable == '0) |=> (!fastRequest && !normalRequest)
	) else $error("disabled channel raised an output");

	chk_active_enable: assert property (
		@(posedge clk) disable iff (reset)
		1'b1 |-> ((active & ~enable) == '0)
	) else $error("disabled channel active");

	// ----------------------------------------
	// checks: classes and priority
	// ----------------------------------------
	chk_fast_class: assert property (
		@(posedge clk) disable iff (reset)
		(fastStatus != '0) |-> ((fastStatus & ~$past(fastSelect)) == '0)
	) else $error("class leak");

	chk_not_fast: assert property (
		@(posedge clk) disable iff (reset)
		(fastAct != '0) |-> ((fastAct & normAct) == '0)
	) else $error("overlap");

	chk_norm_no_fast: assert property (
		@(posedge clk) disable iff (reset)
		1'b1 |-> ((normAct & fastSelect) == '0)
	) else $error("fast channel in vectored set");

	chk_winner_pending: assert property (
		@(posedge clk) disable iff (reset)
		found |-> normAct[winner]
	) else $error("winner not pending");

	chk_found_any: assert property (
		@(posedge clk) disable iff (reset)
		1'b1 |-> (found == (|normAct))
	) else $error("winner flag wrong");

	chk_tie_low: assert property (
		@(posedge clk) disable iff (reset)
		found |-> !lowerTie
	) else $error("tie not lowest");

	chk_prio_best: assert property (
		@(posedge clk) disable iff (reset)
		found |-> !betterExists
	) else $error("not best priority");

	// ----------------------------------------
	// checks: vector, reset and pins
	// ----------------------------------------
	chk_vector_addr: assert property (
		@(posedge clk) disable iff (reset)
		found |=> (vectorAddr == $past(vectorFlat[winner*32 +: 32]))
	) else $error("bad vector");

	chk_channel_match: assert property (
		@(posedge clk) disable iff (reset)
		found |=> (activeChannel == $past(winner))
	) else $error("bad channel");

	chk_vector_idle: assert property (
		@(posedge clk) disable iff (reset)
		!found |=> ((vectorAddr == vrc_pkg::ADDR_RESET) && (activeChannel == '0))
	) else $error("idle vector not cleared");

	chk_reset_quiet: assert property (
		@(posedge clk)
		reset |=> (!fastRequest && !normalRequest && (fastStatus == '0))
	) else $error("outputs not quiet after reset");

	chk_reset_vector: assert property (
		@(posedge clk)
		reset |=> ((vectorAddr == vrc_pkg::ADDR_RESET) && (activeChannel == '0))
	) else $error("vector not cleared by reset");

	chk_ext_merge: assert property (
		@(posedge clk) disable iff (reset)
		portRequest |-> merged[EXT3]
	) else $error("port not merged");

	chk_pin_route: assert property (
		@(posedge clk) disable iff (reset)
		(portRequest && enable[EXT3] && !fastSelect[EXT3]) |=> normalRequest
	) else $error("pin request did not reach normal output");

	chk_pin_status_req: assert property (
		@(posedge clk) disable iff (reset)
		(|pinStatus) |-> portRequest
	) else $error("pin flag without port request");
endmodule

// ---- hw/vrc_pkg.sv ----
// Notes on behaviour
// - there are 32 request inputs, and each one is set to the fast class or the vectored class at run time.
// - fast-class requests always rank above every vectored request.
// - the fast output is the OR of all active fast-class requests.
// - a readable word shows one bit for each fast-class source that is requesting now.
// - every input that is not fast class is a vectored request.
// - each vectored request has a priority level that software sets.
// - among vectored requests of equal priority, the lowest-numbered channel wins.
// - the normal output is the OR of all pending vectored requests.
// - a readable word gives the service routine address of the chosen vectored request.
// - each port pin can raise a request on a rising edge, a falling edge, or both.
// - port-pin edge requests are merged onto the input that carries external request line three.
package vrc_pkg;
	// ----------------------------------------
	// sizes
	// ----------------------------------------
	localparam int NUM_CHANNELS = 32;
	localparam int PRIO_WIDTH = 4;
	localparam int NUM_PORT_PINS = 46;
	localparam int EXT_LINE_THREE_CHANNEL = 17;
	localparam logic [31:0] ADDR_RESET = 32'h0000_0000;
	localparam logic [31:0] CLASS_RESET = 32'h0000_0000;
	localparam logic [31:0] ENABLE_RESET = 32'h0000_0000;
	// ----------------------------------------
	// edge modes
	// ----------------------------------------
	typedef enum logic [1:0] {
		VRC_EDGE_OFF = 2'b00,
		VRC_EDGE_RISE = 2'b01,
		VRC_EDGE_FALL = 2'b10,
		VRC_EDGE_BOTH = 2'b11
	} vrc_edge_t;
endpackage

// ---- hw/vrc_port_edge.sv ----
module vrc_port_edge #(
	parameter int PINS = vrc_pkg::NUM_PORT_PINS
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// pins and configuration
	input wire logic [PINS-1:0] pinIn,
	input wire logic [PINS-1:0] riseEnable,
	input wire logic [PINS-1:0] fallEnable,
	input wire logic [PINS-1:0] pinClear,
	// status
	output logic [PINS-1:0] pinStatus,
	output logic portRequest
);
	initial begin
		if (PINS < 1) $error("vrc_port_edge: PINS must be positive");
	end

	logic [PINS-1:0] sync1_q;
	logic [PINS-1:0] sync2_q;
	logic [PINS-1:0] prev_q;
	logic [PINS-1:0] edgeHit;
	logic [PINS-1:0] pinStatus_q;
	logic [2:0] fill_q;

	// ----------------------------------------
	// two-stage synchroniser; pins are asynchronous
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (reset) begin
			sync1_q <= '0;
			sync2_q <= '0;
			prev_q <= '0;
		end else begin
			sync1_q <= pinIn;
			sync2_q <= sync1_q;
			prev_q <= sync2_q;
		end
	end

	// the chain leaves reset at 0; a pin that sits high would look like a rising
	// edge until all three stages hold real samples, so detection waits for them
	always_ff @(posedge clk) begin
		if (reset) begin
			fill_q <= '0;
		end else begin
			fill_q <= {fill_q[1:0], 1'b1};
		end
	end

	assign edgeHit = fill_q[2]
		? ((riseEnable & sync2_q & ~prev_q) | (fallEnable & ~sync2_q & prev_q)) : '0;

	// ----------------------------------------
	// sticky status, set wins over clear
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (reset) begin
			pinStatus_q <= '0;
		end else begin
			pinStatus_q <= (pinStatus_q & ~pinClear) | edgeHit;
		end
	end

	assign pinStatus = pinStatus_q;
	assign portRequest = |pinStatus_q;

	chk_edge_sets: assert property (@(posedge clk) disable iff (reset)
		(|edgeHit) |=> ((pinStatus_q & $past(edgeHit)) == $past(edgeHit)))
		else $error("edge did not set status");
endmodule

// ---- hw/vrc_prio_pick.sv ----
module vrc_prio_pick #(
	parameter int CHANNELS = vrc_pkg::NUM_CHANNELS,
	parameter int PW = vrc_pkg::PRIO_WIDTH
) (
	// candidates
	input wire logic [CHANNELS-1:0] pending,
	input wire logic [CHANNELS*PW-1:0] prioFlat,
	// winner
	output logic found,
	output logic [$clog2(CHANNELS)-1:0] winner
);
	initial begin
		if (CHANNELS < 2 || PW < 1) $error("vrc_prio_pick: bad sizes");
	end

	// ----------------------------------------
	// lower value is more urgent; scan high to low so
	// the lowest channel wins a tie
	// ----------------------------------------
	always_comb begin
		logic [PW-1:0] best;
		best = '1;
		found = 1'b0;
		winner = '0;
		for (int i = CHANNELS - 1; i >= 0; i--) begin
			if (pending[i] && (!found || prioFlat[i*PW +: PW] <= best)) begin
				found = 1'b1;
				best = prioFlat[i*PW +: PW];
				winner = i[$clog2(CHANNELS)-1:0];
			end
		end
	end
endmodule
